// ### wdt_pkg.sv
// Package for the watchdog unit: register addresses, field positions,
// key values and timing counts.
// Assumes a 100 MHz system clock standing in for the oscillator.
package wdt_pkg;
    // =====================================================================
    // Register map
    localparam logic [7:0] ADDR_RESTART_KEY = 8'ha6;
    localparam logic [7:0] ADDR_AUX_CONTROL = 8'h8e;
    localparam logic [7:0] AUX_RESET_VALUE = 8'h00;
    localparam int BIT_RESET_OUT_DISABLE = 3;
    localparam int BIT_IDLE_FREEZE = 4;
    // =====================================================================
    // Key sequence
    localparam logic [7:0] KEY_FIRST = 8'h1e;
    localparam logic [7:0] KEY_SECOND = 8'he1;
    // =====================================================================
    // Timing
    localparam int COUNT_WIDTH = 14;
    localparam logic [13:0] COUNT_OVERFLOW = 14'h3fff;
    localparam int OSC_PER_MACHINE_CYCLE = 12;
    localparam int PULSE_OSC_PERIODS = 98;
    localparam int RESET_PIN_MACHINE_CYCLES = 2;
    localparam int RESET_PIN_OSC = RESET_PIN_MACHINE_CYCLES * OSC_PER_MACHINE_CYCLE;
    // Key sequencer states
    typedef enum logic [0:0] {KEY_IDLE, KEY_ARMED} key_state_t;
endpackage

// ### wdt_tick.sv
// Machine-cycle tick generator: one pulse every N oscillator periods.
// Assumes the clock is the running oscillator; oscillator stop freezes it.
`timescale 1ns/10ps
module wdt_tick #(
    parameter int DIVIDE = 12
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    output logic tick
);
    // =====================================================================
    // Divider
    localparam int W = $clog2(DIVIDE);
    logic [W-1:0] cnt_q;
    logic wrap;
    initial begin
        if (DIVIDE < 2) $error("DIVIDE must be at least 2");
    end
    assign wrap = (cnt_q == W'(DIVIDE - 1));
    assign tick = run && wrap;
    // Count oscillator periods while running
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (run) begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
        end
    end
endmodule

// ### wdt_pulse.sv
// Fixed-length pulse stretcher for the reset-out drive.
// Assumes start is a single-cycle pulse in the oscillator domain.
`timescale 1ns/10ps
module wdt_pulse #(
    parameter int LENGTH = 98
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    output logic busy
);
    // =====================================================================
    // Length counter
    localparam int W = $clog2(LENGTH + 1);
    logic [W-1:0] left_q;
    initial begin
        if (LENGTH < 1) $error("LENGTH must be at least 1");
    end
    assign busy = (left_q != '0);
    // Load on start, count down to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            left_q <= '0;
        end else if (start) begin
            left_q <= W'(LENGTH);
        end else if (busy) begin
            left_q <= left_q - 1'b1;
        end
    end
endmodule

// ### wdt_top.sv
// Watchdog unit with idle and power-down handling and reset-out pin drive.
// Assumes CLK_SYS is the oscillator; an oscillator stop is represented by the OSC_RUN level,
// and its gating in power-down by the internal power-down state.
`timescale 1ns/10ps
// Behaviour
// - After any reset the watchdog stays disabled until the key sequence.
// - Writing 1e then e1 to the restart key register enables it.
// - Enabled counter advances once per machine cycle while oscillator runs.
// - 14-bit counter overflows at 3fff and resets the device; aux control at 8e keeps its value.
// - Once enabled only a reset disables it; no write can.
// - Key sequence while enabled restarts the counter from zero.
// - Restart key register is write-only; reads return zero.
// - Counter is neither readable nor directly writable.
// - Overflow drives the reset pin high for 98 oscillator periods.
// - In power-down the counter holds its value.
// - Power-down ends on hardware reset or enabled level external interrupt.
// - After interrupt wake the counter waits until the interrupt pin goes high.
// - With idle freeze clear the watchdog counts in idle.
// - With idle freeze set the count pauses in idle and resumes after.
// - Idle ends on any enabled interrupt or hardware reset.
// - Aux control at 8e holds reset-out disable bit 3, idle freeze bit 4.
// - Reset-out disable 0 drives pin after overflow; 1 leaves it input only.
// - Reset pin high for two machine cycles resets device and watchdog.
module wdt_top #(
    parameter int PULSE_LEN = wdt_pkg::PULSE_OSC_PERIODS,
    parameter int DIVIDE = wdt_pkg::OSC_PER_MACHINE_CYCLE
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Power modes and interrupts
    input wire logic OSC_RUN,
    input wire logic IDLE_REQ,
    input wire logic PD_REQ,
    input wire logic IRQ_PENDING,
    input wire logic EXT_IRQ_ZERO_N,
    input wire logic EXT_IRQ_ONE_N,
    input wire logic EXT_IRQ_ZERO_EN,
    input wire logic EXT_IRQ_ONE_EN,
    output logic IDLE_ACTIVE,
    output logic PD_ACTIVE,
    // Reset pin (two-way), internal device reset and watchdog enable status
    input wire logic RST_PIN_IN,
    output logic RST_PIN_OUT,
    output logic RST_PIN_OE,
    output logic DEVICE_RESET,
    output logic WDT_ENABLED
);
    initial begin
        if (PULSE_LEN < 1) $error("PULSE_LEN must be at least 1");
        if (DIVIDE < 2) $error("DIVIDE must be at least 2");
        if (DIVIDE > 16) $error("DIVIDE must be at most 16 for the pin hold counter");
    end

    // =====================================================================
    // Decode
    logic wr_key, wr_aux, rd_aux;
    assign wr_key = WR && (ADDR == wdt_pkg::ADDR_RESTART_KEY);
    assign wr_aux = WR && (ADDR == wdt_pkg::ADDR_AUX_CONTROL);
    assign rd_aux = RD && (ADDR == wdt_pkg::ADDR_AUX_CONTROL);

    // =====================================================================
    // State
    logic [7:0] aux_q;
    logic enabled_q;
    logic [13:0] count_q, count_d;
    wdt_pkg::key_state_t key_q, key_d;
    logic idle_q, pd_q, wake_hold_q;
    logic [4:0] pin_cnt_q;
    logic pin_reset_q;
    logic overflow_q;
    logic [7:0] rdata_q;
    logic rst_out_q, rst_oe_q, dev_rst_q;
    logic tick, pulse_busy;
    logic key_done, overflow, all_reset;
    logic idle_freeze, reset_out_disable;
    logic wake_irq, count_run, osc_run;
    logic [4:0] pin_hold_last;
    // Pin hold length follows the machine cycle, not a fixed oscillator count
    assign pin_hold_last = 5'(wdt_pkg::RESET_PIN_MACHINE_CYCLES * DIVIDE - 1);

    assign idle_freeze = aux_q[wdt_pkg::BIT_IDLE_FREEZE];
    assign reset_out_disable = aux_q[wdt_pkg::BIT_RESET_OUT_DISABLE];
    // Internal reset: hardware reset, pin reset or own overflow
    assign all_reset = SRST || pin_reset_q || overflow_q;
    // Oscillator effectively stopped while powered down
    assign osc_run = OSC_RUN && !pd_q;
    // Level-activated enabled external interrupt wakes from power-down
    assign wake_irq = (!EXT_IRQ_ZERO_N && EXT_IRQ_ZERO_EN)
                    || (!EXT_IRQ_ONE_N && EXT_IRQ_ONE_EN);

    // =====================================================================
    // Machine-cycle tick
    wdt_tick #(
        .DIVIDE(DIVIDE)
    ) u_tick (
        .clk(CLK_SYS),
        .srst(SRST),
        .run(osc_run),
        .tick(tick)
    );

    // =====================================================================
    // Key sequencer
    always_comb begin
        key_d = key_q;
        key_done = 1'b0;
        case (key_q)
            wdt_pkg::KEY_IDLE: begin
                if (wr_key && WDATA == wdt_pkg::KEY_FIRST) begin
                    key_d = wdt_pkg::KEY_ARMED;
                end
            end
            wdt_pkg::KEY_ARMED: begin
                if (wr_key) begin
                    key_done = (WDATA == wdt_pkg::KEY_SECOND);
                    key_d = (WDATA == wdt_pkg::KEY_FIRST) ? wdt_pkg::KEY_ARMED
                                                          : wdt_pkg::KEY_IDLE;
                end
            end
            default: key_d = wdt_pkg::KEY_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (all_reset) begin
            key_q <= wdt_pkg::KEY_IDLE;
        end else begin
            key_q <= key_d;
        end
    end

    // =====================================================================
    // Counter gating and next value
    assign count_run = enabled_q && tick && !wake_hold_q
                     && !(idle_q && idle_freeze);
    assign overflow = count_run && (count_q == wdt_pkg::COUNT_OVERFLOW - 14'h0001);
    always_comb begin
        count_d = count_q;
        if (key_done) begin
            count_d = '0;
        end else if (count_run) begin
            count_d = count_q + 14'h0001;
        end
    end

    // Enable latch and counter; no bus path reads or writes the count
    always_ff @(posedge CLK_SYS) begin
        if (all_reset) begin
            enabled_q <= 1'b0;
            count_q <= '0;
        end else begin
            enabled_q <= enabled_q || key_done;
            count_q <= count_d;
        end
    end

    // Overflow reset request, one cycle
    always_ff @(posedge CLK_SYS) begin
        if (SRST || pin_reset_q || overflow_q) begin
            overflow_q <= 1'b0;
        end else begin
            overflow_q <= overflow;
        end
    end

    // =====================================================================
    // Reset-out pulse
    wdt_pulse #(
        .LENGTH(PULSE_LEN)
    ) u_pulse (
        .clk(CLK_SYS),
        .srst(SRST),
        .start(overflow),
        .busy(pulse_busy)
    );

    // =====================================================================
    // Auxiliary control register
    always_ff @(posedge CLK_SYS) begin
        if (SRST || pin_reset_q) begin
            aux_q <= wdt_pkg::AUX_RESET_VALUE;
        end else if (wr_aux) begin
            aux_q <= WDATA;
        end
    end

    // =====================================================================
    // Idle and power-down
    always_ff @(posedge CLK_SYS) begin
        if (all_reset) begin
            idle_q <= 1'b0;
            pd_q <= 1'b0;
            wake_hold_q <= 1'b0;
        end else begin
            if (IRQ_PENDING) begin
                idle_q <= 1'b0;
            end else if (IDLE_REQ) begin
                idle_q <= 1'b1;
            end
            if (pd_q && wake_irq) begin
                pd_q <= 1'b0;
                wake_hold_q <= 1'b1;
            end else if (PD_REQ) begin
                pd_q <= 1'b1;
            end
            if (wake_hold_q && EXT_IRQ_ZERO_N && EXT_IRQ_ONE_N) begin
                wake_hold_q <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Reset pin detector: high for two machine cycles while running
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pin_cnt_q <= '0;
            pin_reset_q <= 1'b0;
        end else if (!RST_PIN_IN || rst_oe_q) begin
            pin_cnt_q <= '0;
            pin_reset_q <= 1'b0;
        end else if (osc_run) begin
            if (pin_cnt_q == pin_hold_last) begin
                pin_reset_q <= 1'b1;
            end else begin
                pin_cnt_q <= pin_cnt_q + 5'h01;
            end
        end
    end

    // =====================================================================
    // Outputs and read data
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rdata_q <= 8'h00;
            rst_out_q <= 1'b0;
            rst_oe_q <= 1'b0;
            dev_rst_q <= 1'b0;
        end else begin
            rdata_q <= rd_aux ? aux_q : 8'h00;
            rst_out_q <= pulse_busy && !reset_out_disable;
            rst_oe_q <= pulse_busy && !reset_out_disable;
            dev_rst_q <= overflow_q || pin_reset_q;
        end
    end

    assign RDATA = rdata_q;
    assign RST_PIN_OUT = rst_out_q;
    assign RST_PIN_OE = rst_oe_q;
    assign DEVICE_RESET = dev_rst_q;
    assign WDT_ENABLED = enabled_q;
    assign IDLE_ACTIVE = idle_q;
    assign PD_ACTIVE = pd_q;
endmodule

// ### wdt_assertions.sv
// Checker for the watchdog unit, seeing only the top module ports.
// Assumes one clock domain and SRST synchronous, active high.
`timescale 1ns/10ps
module wdt_assertions #(
    parameter int PULSE_LEN = 98,
    parameter int DIVIDE = 12
) (
    // Observed ports
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic OSC_RUN,
    input wire logic IRQ_PENDING,
    input wire logic EXT_IRQ_ZERO_N,
    input wire logic EXT_IRQ_ZERO_EN,
    input wire logic IDLE_ACTIVE,
    input wire logic PD_ACTIVE,
    input wire logic RST_PIN_IN,
    input wire logic RST_PIN_OUT,
    input wire logic RST_PIN_OE,
    input wire logic DEVICE_RESET,
    input wire logic WDT_ENABLED
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    logic [7:0] oe_cnt_q;
    logic [7:0] pin_cnt_q;
    // =====================================================================
    // Helper counters: drive length and pin hold length
    always_ff @(posedge CLK_SYS) begin
        oe_cnt_q <= RST_PIN_OE ? oe_cnt_q + 8'h01 : 8'h00;
        if (!RST_PIN_IN || RST_PIN_OE || !OSC_RUN) begin
            pin_cnt_q <= 8'h00;
        end else if (pin_cnt_q != 8'hff) begin
            pin_cnt_q <= pin_cnt_q + 8'h01;
        end
    end
    sequence key_first_s;
        WR && ADDR == 8'ha6 && WDATA == 8'h1e;
    endsequence
    sequence key_second_s;
        WR && ADDR == 8'ha6 && WDATA == 8'he1;
    endsequence
    // =====================================================================
    // Properties
    reset_clear_a: assert property ($fell(SRST) |-> !WDT_ENABLED && !RST_PIN_OE)
        else $error("outputs active after reset");
    enable_key_a: assert property (key_first_s ##1 key_second_s |=> WDT_ENABLED)
        else $error("key pair did not enable");
    stay_enabled_a: assert property ($fell(WDT_ENABLED) |-> ##[0:1] DEVICE_RESET)
        else $error("enable dropped without reset");
    reset_pulse_a: assert property (DEVICE_RESET && RST_PIN_OE |=> !DEVICE_RESET)
        else $error("overflow device reset longer than one cycle");
    pulse_start_a: assert property ($rose(RST_PIN_OE) |-> DEVICE_RESET)
        else $error("pin drive without device reset");
    pulse_len_a: assert property ($fell(RST_PIN_OE) |-> oe_cnt_q == PULSE_LEN)
        else $error("pin drive length wrong");
    drive_high_a: assert property (RST_PIN_OE |-> RST_PIN_OUT)
        else $error("pin driven low");
    read_zero_a: assert property (RD && ADDR != 8'h8e |=> RDATA == 8'h00)
        else $error("read leaked data");
    pin_reset_a: assert property (pin_cnt_q == 8'(2 * DIVIDE - 1) && RST_PIN_IN
        |-> ##[1:3] DEVICE_RESET)
        else $error("pin hold did not reset");
    pd_wake_a: assert property (PD_ACTIVE && EXT_IRQ_ZERO_EN && !EXT_IRQ_ZERO_N
        |-> ##[1:2] !PD_ACTIVE)
        else $error("power-down not left");
    idle_end_a: assert property (IDLE_ACTIVE && IRQ_PENDING |-> ##[1:2] !IDLE_ACTIVE)
        else $error("idle not left");
endmodule
bind wdt_top wdt_assertions #(.PULSE_LEN(PULSE_LEN), .DIVIDE(DIVIDE)) chk_i (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .OSC_RUN(OSC_RUN), .IRQ_PENDING(IRQ_PENDING),
    .EXT_IRQ_ZERO_N(EXT_IRQ_ZERO_N), .EXT_IRQ_ZERO_EN(EXT_IRQ_ZERO_EN),
    .IDLE_ACTIVE(IDLE_ACTIVE), .PD_ACTIVE(PD_ACTIVE), .RST_PIN_IN(RST_PIN_IN),
    .RST_PIN_OUT(RST_PIN_OUT), .RST_PIN_OE(RST_PIN_OE), .DEVICE_RESET(DEVICE_RESET),
    .WDT_ENABLED(WDT_ENABLED));

// ### wdt_top_tb.sv
// Testbench for the watchdog unit: registers, keys, overflow, power modes.
// Assumes wdt_top with the bound checker; machine cycle shortened to 4.
`timescale 1ns/10ps
module wdt_top_tb;
    localparam int DIV = 4;
    localparam int PLEN = 98;
    logic CLK_SYS = 1'b0;
    logic SRST = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic OSC_RUN = 1'b1;
    logic IDLE_REQ = 1'b0;
    logic PD_REQ = 1'b0;
    logic IRQ_PENDING = 1'b0;
    logic EXT_IRQ_ZERO_N = 1'b1;
    logic EXT_IRQ_ZERO_EN = 1'b0;
    logic pin_drive = 1'b0;
    logic [7:0] RDATA;
    logic IDLE_ACTIVE, PD_ACTIVE, RST_PIN_OUT, RST_PIN_OE, DEVICE_RESET, WDT_ENABLED;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int t0, tpd, n;
    // Reset pin level: the unit's drive wins, else the bench's level
    wire logic RST_PIN_IN = RST_PIN_OE ? RST_PIN_OUT : pin_drive;
    // =====================================================================
    // Clock, cycle count and hang limit
    always #5 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            errors++;
            complete_run();
        end
    end
    wdt_top #(.PULSE_LEN(PLEN), .DIVIDE(DIV)) dut (
        .CLK_SYS(CLK_SYS), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .OSC_RUN(OSC_RUN), .IDLE_REQ(IDLE_REQ), .PD_REQ(PD_REQ),
        .IRQ_PENDING(IRQ_PENDING), .EXT_IRQ_ZERO_N(EXT_IRQ_ZERO_N), .EXT_IRQ_ONE_N(1'b1),
        .EXT_IRQ_ZERO_EN(EXT_IRQ_ZERO_EN), .EXT_IRQ_ONE_EN(1'b0), .IDLE_ACTIVE(IDLE_ACTIVE),
        .PD_ACTIVE(PD_ACTIVE), .RST_PIN_IN(RST_PIN_IN), .RST_PIN_OUT(RST_PIN_OUT),
        .RST_PIN_OE(RST_PIN_OE), .DEVICE_RESET(DEVICE_RESET), .WDT_ENABLED(WDT_ENABLED));
    // =====================================================================
    // Comparison, bus and closing tasks
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    // Key pair on two back-to-back write strobes
    task wr_key;
        ADDR <= 8'ha6;
        WDATA <= 8'h1e;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WDATA <= 8'he1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 chk8(RDATA, exp);
        @(posedge CLK_SYS);
    endtask
    task complete_run;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // =====================================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge CLK_SYS);
        SRST <= 1'b0;
        @(posedge CLK_SYS);
        chk1(WDT_ENABLED, 1'b0);
        rd(8'h8e, 8'h00);
        rd(8'ha6, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h8e, 8'h18);
        rd(8'h8e, 8'h18);
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'h55);
        wr(8'ha6, 8'he1);
        chk1(WDT_ENABLED, 1'b0);
        wr_key();
        chk1(WDT_ENABLED, 1'b1);
        wr(8'h8e, 8'h10);
        wr(8'ha6, 8'h00);
        chk1(WDT_ENABLED, 1'b1);
        IDLE_REQ <= 1'b1;
        @(posedge CLK_SYS);
        IDLE_REQ <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        chk1(IDLE_ACTIVE, 1'b1);
        IRQ_PENDING <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        chk1(IDLE_ACTIVE, 1'b0);
        IRQ_PENDING <= 1'b0;
        wr(8'h8e, 8'h00);
        repeat (100) @(posedge CLK_SYS);
        wr_key();
        t0 = cyc;
        EXT_IRQ_ZERO_EN <= 1'b1;
        repeat (2000) @(posedge CLK_SYS);
        tpd = cyc;
        OSC_RUN <= 1'b0;
        repeat (200) @(posedge CLK_SYS);
        OSC_RUN <= 1'b1;
        PD_REQ <= 1'b1;
        @(posedge CLK_SYS);
        PD_REQ <= 1'b0;
        repeat (1000) @(posedge CLK_SYS);
        chk1(PD_ACTIVE, 1'b1);
        EXT_IRQ_ZERO_N <= 1'b0;
        repeat (50) @(posedge CLK_SYS);
        chk1(PD_ACTIVE, 1'b0);
        EXT_IRQ_ZERO_N <= 1'b1;
        tpd = cyc - tpd;
        n = 0;
        while (DEVICE_RESET !== 1'b1 && n < 70000) begin
            @(posedge CLK_SYS);
            n++;
        end
        n = cyc - t0 - tpd - 16383 * DIV;
        chk1(n >= -8 && n <= 12, 1'b1);
        chk1(RST_PIN_OE, 1'b1);
        n = 0;
        while (RST_PIN_OE === 1'b1 && n < 200) begin
            @(posedge CLK_SYS);
            n++;
        end
        chk1(n == PLEN, 1'b1);
        chk1(WDT_ENABLED, 1'b0);
        wr_key();
        pin_drive <= 1'b1;
        repeat (2 * DIV - 2) @(posedge CLK_SYS);
        chk1(WDT_ENABLED, 1'b1);
        repeat (10) @(posedge CLK_SYS);
        chk1(WDT_ENABLED, 1'b0);
        chk1(DEVICE_RESET, 1'b1);
        pin_drive <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        chk1(DEVICE_RESET, 1'b0);
        complete_run();
    end
endmodule
